// >>> verilog/asx_pkg.sv
// Constants and types shared by the subtract/xor/swap datapath.
// Assumes a single core clock and a synchronous active-low reset.
package asx_pkg;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned NIB_W   = 4;
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic        DEST_ACC  = 1'b0;
  localparam logic        DEST_FILE = 1'b1;

  // Operation select codes from the decoder
  typedef enum logic [1:0] {
    OP_SUB_ACC_FROM_FILE = 2'h0,
    OP_XOR_IMM_INTO_ACC  = 2'h1,
    OP_NIBBLE_EXCHANGE   = 2'h2,
    OP_XOR_ACC_WITH_FILE = 2'h3
  } asx_op_e;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } asx_state_e;
endpackage

// >>> verilog/asx_alu.sv
// Combinational result and flag generator for the four operations.
// Assumes operands are stable within the cycle; no state held here.
`timescale 1ns/1ps
module asx_alu (
  input  wire asx_pkg::asx_op_e op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       fval,
  input  wire logic [7:0]       imm,
  output logic      [7:0]       res,
  output logic                  carry,
  output logic                  half_borrow_bit,
  output logic                  zero,
  output logic                  carry_en,
  output logic                  hb_en,
  output logic                  zero_en
);
  logic [8:0] diff;
  logic [4:0] ndiff;

  ////////////////////////////////////////////////////////////////////////
  // Subtract via add of inverted operand plus one: carry out is not-borrow
  always_comb begin
    diff  = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
    ndiff = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    res             = 8'h00;
    carry           = diff[8];
    half_borrow_bit = ndiff[4];
    carry_en        = 1'b0;
    hb_en           = 1'b0;
    zero_en         = 1'b0;
    case (op)
      asx_pkg::OP_SUB_ACC_FROM_FILE: begin
        res      = diff[7:0];
        carry_en = 1'b1;
        hb_en    = 1'b1;
        zero_en  = 1'b1;
      end
      asx_pkg::OP_XOR_IMM_INTO_ACC: begin
        res     = acc ^ imm;
        zero_en = 1'b1;
      end
      asx_pkg::OP_NIBBLE_EXCHANGE: begin
        res = {fval[3:0], fval[7:4]};
      end
      asx_pkg::OP_XOR_ACC_WITH_FILE: begin
        res     = acc ^ fval;
        zero_en = 1'b1;
      end
      default: res = 8'h00;
    endcase
    zero = (res == 8'h00);
  end
endmodule

// >>> verilog/asx_datapath.sv
// Top of the subtract/xor/swap datapath: accumulator, flags, file access.
// Assumes the decoder and file memory share CLOCK; file reads answer in the
// same cycle that FILE_RD_EN is high, with FILE_RD_DATA.
`timescale 1ns/1ps
module asx_datapath (
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  input  wire logic       OP_VALID,
  input  wire logic [1:0] OP_SEL,
  input  wire logic [6:0] FILE_ADDR,
  input  wire logic       DEST_SEL,
  input  wire logic [7:0] IMM_DATA,
  input  wire logic [7:0] FILE_RD_DATA,
  output logic            OP_READY,
  output logic            OP_DONE,
  output logic            FILE_RD_EN,
  output logic            FILE_WR_EN,
  output logic [6:0]      FILE_WR_ADDR,
  output logic [7:0]      FILE_WR_DATA,
  output logic [7:0]      ACC,
  output logic            CARRY,
  output logic            HALF_BORROW_BIT,
  output logic            ZERO
);
  typedef struct packed {
    asx_pkg::asx_state_e st;
    asx_pkg::asx_op_e    op;
    logic [6:0]          addr;
    logic                dest;
    logic                rd_en;
    logic                wr_en;
    logic [7:0]          wr_data;
    logic                done;
    logic [7:0]          acc;
    logic                carry;
    logic                hb;
    logic                zero;
    logic                ready;
  } asx_state_s;

  asx_state_s s_q, s_d;

  logic [7:0]       alu_res;
  logic             alu_c;
  logic             alu_hb;
  logic             alu_z;
  logic             c_en;
  logic             hb_en;
  logic             z_en;
  logic [7:0]       f_operand;
  asx_pkg::asx_op_e op_req;
  logic             idle;
  logic             take;
  logic             take_imm;
  logic             take_file;
  logic [7:0]       imm_res;
  logic             imm_zero;

  ////////////////////////////////////////////////////////////////////////
  // Operation code as the decoder presents it on OP_SEL.
  // Kept in one place so every decode of the request agrees.
  function automatic asx_pkg::asx_op_e op_decode(input logic [1:0] code);
    return asx_pkg::asx_op_e'(code);
  endfunction

  // Zero test for the immediate path; the file-op commit takes its zero flag
  // from the ALU's own zero output instead of this function.
  function automatic logic is_zero(input logic [7:0] value);
    return (value == '0);
  endfunction

  // True for the operations that need a file read before they commit
  function automatic logic needs_file(input asx_pkg::asx_op_e code);
    return (code != asx_pkg::OP_XOR_IMM_INTO_ACC);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // File operand is only meaningful in BUSY, when the read has answered
  assign f_operand = FILE_RD_DATA;

  asx_alu u_alu (
    .op              (s_q.op),
    .acc             (s_q.acc),
    .fval            (f_operand),
    .imm             (IMM_DATA),
    .res             (alu_res),
    .carry           (alu_c),
    .half_borrow_bit (alu_hb),
    .zero            (alu_z),
    .carry_en        (c_en),
    .hb_en           (hb_en),
    .zero_en         (z_en)
  );

  ////////////////////////////////////////////////////////////////////////
  // Request decode. A request is taken only while idle; one offered while
  // busy is dropped without any indication, so the decoder must watch
  // OP_READY before it offers the next operation.
  assign op_req    = op_decode(OP_SEL);
  assign idle      = (s_q.st == asx_pkg::ST_IDLE);
  assign take      = OP_VALID && idle;
  assign take_imm  = take && !needs_file(op_req);
  assign take_file = take && needs_file(op_req);

  // Immediate path result, computed while the literal is on IMM_DATA.
  // The literal is not held, which is why this path cannot go through
  // the registered ALU operand like the file operations do.
  assign imm_res  = s_q.acc ^ IMM_DATA;
  assign imm_zero = is_zero(imm_res);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: immediate op finishes in one step, file ops read then commit.
  // Pulses (read, write, done) fall back to zero unless set in this cycle.
  always_comb begin
    s_d       = s_q;
    s_d.rd_en = 1'b0;
    s_d.wr_en = 1'b0;
    s_d.done  = 1'b0;
    case (s_q.st)
      asx_pkg::ST_IDLE: begin
        // Immediate op: only the accumulator and zero flag move
        if (take_imm) begin
          s_d.acc  = imm_res;
          s_d.zero = imm_zero;
          s_d.done = 1'b1;
        end
        // File op: latch address and destination, then ask for the byte
        if (take_file) begin
          s_d.op    = op_req;
          s_d.addr  = FILE_ADDR;
          s_d.dest  = DEST_SEL;
          s_d.rd_en = 1'b1;
          s_d.st    = asx_pkg::ST_BUSY;
        end
      end
      asx_pkg::ST_BUSY: begin
        // Read data is valid now; commit result and flags together
        if (s_q.dest == asx_pkg::DEST_FILE) begin
          s_d.wr_en   = 1'b1;
          s_d.wr_data = alu_res;
        end else begin
          s_d.acc = alu_res;
        end
        // Flags move only where the operation is allowed to touch them;
        // the nibble exchange leaves all three alone
        if (c_en) begin
          s_d.carry = alu_c;
        end
        if (hb_en) begin
          s_d.hb = alu_hb;
        end
        if (z_en) begin
          s_d.zero = alu_z;
        end
        s_d.done = 1'b1;
        s_d.st   = asx_pkg::ST_IDLE;
      end
      default: begin
        // Illegal state code: drop back to idle and wait for a request
        s_d.st = asx_pkg::ST_IDLE;
      end
    endcase
    // Ready is registered so the output comes straight from a flop
    s_d.ready = (s_d.st == asx_pkg::ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; flags and accumulator clear on reset
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      s_q         <= '0;
      s_q.st      <= asx_pkg::ST_IDLE;
      s_q.op      <= asx_pkg::OP_SUB_ACC_FROM_FILE;
      s_q.acc     <= asx_pkg::ACC_RST;
      s_q.ready   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  // No gate sits between a flop and a pin, so downstream timing is clean.
  // The write address doubles as the read address for the file model.
  assign OP_READY        = s_q.ready;
  assign OP_DONE         = s_q.done;
  assign FILE_RD_EN      = s_q.rd_en;
  assign FILE_WR_EN      = s_q.wr_en;
  assign FILE_WR_ADDR    = s_q.addr;
  assign FILE_WR_DATA    = s_q.wr_data;
  assign ACC             = s_q.acc;
  assign CARRY           = s_q.carry;
  assign HALF_BORROW_BIT = s_q.hb;
  assign ZERO            = s_q.zero;
endmodule

// >>> testbench/asx_chk.sv
// Port checker for the subtract/xor/swap datapath.
// Assumes it is bound to every datapath instance below.
`timescale 1ns/1ps
module asx_chk (
  input wire logic       CLOCK, RSTN, OP_VALID, DEST_SEL, OP_READY, OP_DONE,
  input wire logic       FILE_RD_EN, FILE_WR_EN, CARRY, HALF_BORROW_BIT, ZERO,
  input wire logic [1:0] OP_SEL,
  input wire logic [6:0] FILE_ADDR, FILE_WR_ADDR,
  input wire logic [7:0] IMM_DATA, FILE_RD_DATA, FILE_WR_DATA, ACC
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  logic [1:0] op_q;
  logic       dst_q;
  logic [7:0] res;
  // Op kept from the take, since its answer lands two edges on
  always_ff @(posedge CLOCK) begin
    if (OP_VALID && OP_READY) begin
      op_q  <= OP_SEL;
      dst_q <= DEST_SEL;
    end
  end
  // Expected file-op result while the read data is on the bus
  assign res = op_q == 2'h0 ? FILE_RD_DATA - ACC : op_q == 2'h2 ?
               {FILE_RD_DATA[3:0], FILE_RD_DATA[7:4]} : FILE_RD_DATA ^ ACC;
  sequence take_f_s; OP_VALID && OP_READY && OP_SEL != 2'h1; endsequence
  sequence rd_s; FILE_RD_EN && !OP_READY ##1 OP_DONE; endsequence
  file_steps_a: assert property (take_f_s |=> rd_s)
    else $error("file op steps");
  addr_keep_a: assert property (take_f_s |=> FILE_WR_ADDR == $past(FILE_ADDR))
    else $error("file address");
  imm_xor_a: assert property (OP_VALID && OP_READY && OP_SEL == 2'h1 |=> OP_DONE &&
    ACC == $past(ACC ^ IMM_DATA) && $stable(CARRY) && $stable(HALF_BORROW_BIT))
    else $error("literal xor");
  to_acc_a: assert property (FILE_RD_EN && !dst_q |=> ACC == $past(res) && !FILE_WR_EN)
    else $error("result to acc");
  to_file_a: assert property (FILE_RD_EN && dst_q |=> FILE_WR_EN &&
    FILE_WR_DATA == $past(res) && $stable(ACC)) else $error("result to file");
  sub_flags_a: assert property (FILE_RD_EN && op_q == 2'h0 |=> CARRY ==
    $past(ACC <= FILE_RD_DATA) && HALF_BORROW_BIT == $past(ACC[3:0] <= FILE_RD_DATA[3:0]))
    else $error("borrow flags");
  swap_flags_a: assert property (FILE_RD_EN && op_q == 2'h2 |=>
    $stable({CARRY, HALF_BORROW_BIT, ZERO})) else $error("swap flags");
  zero_flag_a: assert property (FILE_RD_EN && op_q != 2'h2 |=>
    ZERO == $past(res == 8'h00)) else $error("zero flag");
endmodule

bind asx_datapath asx_chk u_chk (.*);

// >>> testbench/asx_fmem.sv
// File register model answering the datapath's read and write pulses.
// Assumes read data is wanted while rd_en is high.
`timescale 1ns/1ps
module asx_fmem (
  input  wire logic       clk,
  input  wire logic       rd_en,
  input  wire logic       wr_en,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);
  logic [7:0] mem [128];
  // Inverted outside a read so a stale value never passes
  assign rd_data = rd_en ? mem[addr] : ~mem[addr];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 29);
  // Write-back commits at the edge
  always @(posedge clk) if (wr_en) mem[addr] <= wr_data;
endmodule

// >>> testbench/tb_top.sv
// Bench: corner and random ops on the datapath, results predicted here.
// Assumes the file model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'h0, rstn = 1'h0, vld = 1'h0, dst = 1'h0;
  logic [1:0]  sel = 2'h0;
  logic [6:0]  adr = 7'h00, wa;
  logic [7:0]  imm = 8'h00, rdd, wd, acc, e_acc = 8'h00;
  logic [2:0]  e_flg = 3'h0;
  logic [31:0] rnd;
  logic        rdy, done, re, we, c, h, z;
  int          errors = 0, n_tests = 0, seed = 69;
  initial forever #2.5 clk = ~clk;
  asx_datapath uut (.CLOCK(clk), .RSTN(rstn), .OP_VALID(vld), .OP_SEL(sel),
    .FILE_ADDR(adr), .DEST_SEL(dst), .IMM_DATA(imm), .FILE_RD_DATA(rdd),
    .OP_READY(rdy), .OP_DONE(done), .FILE_RD_EN(re), .FILE_WR_EN(we),
    .FILE_WR_ADDR(wa), .FILE_WR_DATA(wd), .ACC(acc), .CARRY(c),
    .HALF_BORROW_BIT(h), .ZERO(z));
  asx_fmem u_mem (.clk(clk), .rd_en(re), .wr_en(we), .addr(wa), .wr_data(wd),
    .rd_data(rdd));
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One op: issue, predict from the mirror, wait for done, compare
  task automatic op(logic [1:0] s, logic [6:0] a, logic d, logic [7:0] k);
    logic [7:0] f, r;
    logic [2:0] fl;
    logic       w;
    int         t;
    @(posedge clk);
    {vld, sel, adr, dst, imm} <= {1'h1, s, a, d, k};
    #1;
    // Earlier write-back has landed now, so the mirror read is current
    f = u_mem.mem[a];
    fl = e_flg;
    w = s != 2'h1 && d;
    case (s)
      2'h0: r = f - e_acc;
      2'h1: r = e_acc ^ k;
      2'h2: r = {f[3:0], f[7:4]};
      default: r = e_acc ^ f;
    endcase
    if (s == 2'h0) fl[2:1] = {e_acc <= f, e_acc[3:0] <= f[3:0]};
    if (s != 2'h2) fl[0] = r == 8'h00;
    if (!w) e_acc = r;
    e_flg = fl;
    @(posedge clk);
    vld <= 1'h0;
    #1;
    for (t = 0; t < 4 && done !== 1'h1; t++) begin
      @(posedge clk);
      #1;
    end
    if (t == 4) begin
      errors++;
      test_done();
    end
    chk({acc, c, h, z, we}, {e_acc, fl, w});
    if (w) chk({wa, wd}, {a, r});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    // Corners: equal operands, all-ones literal, borrow, top address
    op(2'h0, 7'h00, 1'h0, 8'h00);
    op(2'h1, 7'h00, 1'h0, 8'hff);
    op(2'h0, 7'h01, 1'h1, 8'h00);
    op(2'h2, 7'h7f, 1'h0, 8'h00);
    op(2'h3, 7'h7f, 1'h1, 8'h00);
    repeat (400) begin
      rnd = $random(seed);
      op(rnd[1:0], rnd[8:2], rnd[9], rnd[17:10]);
    end
    test_done();
  end
endmodule
